// ==== vector_irq_ctrl.sv ====
// Purpose: Vectored eight-level priority interrupt controller, APB slave
// Assumes: Sources are pins or other clocks, synchronised here
// Notes:   Zero-wait APB; debug stacking variant not provided
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
module vector_irq_ctrl (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_psel,
   input  wire logic                        i_penable,
   input  wire logic                        i_pwrite,
   input  wire logic [11:0]                 i_paddr,
   input  wire logic [31:0]                 i_pwdata,
   input  wire logic [vector_irq_pkg::NUM_CH-1:0] i_src,
   output logic      [31:0]                 o_prdata,
   output logic                             o_pready,
   output logic                             o_pslverr,
   output logic                             o_irq_request_n,
   output logic                             o_fast_irq_request
);
   import vector_irq_pkg::*;

   apb_req_s          req;
   logic [NUM_CH-1:0] sync1_r;
   logic [NUM_CH-1:0] sync2_r;
   logic [NUM_CH-1:0] prev_r;
   logic [7:0]        ctl [NUM_CH];
   logic [NUM_CH-1:0] mask_r;
   logic [NUM_CH-1:0] status;
   logic [NUM_CH-1:0] active;
   logic [NUM_CH-1:0] lvl0_ch;
   logic [NUM_LVL-1:0] stack_r [NUM_LVL];
   logic [3:0]        depth_r;
   logic [3:0]        cur_lvl_r;
   logic [4:0]        src_num_r;
   logic [4:0]        win_ch;
   logic [3:0]        win_lvl;
   logic              win_any;
   logic              irq_r;
   logic              access;
   logic              rd_encode;
   logic              wr_cmd;
   logic              valid_hit;
   logic [31:0]       rdata_nxt;
   logic [4:0]        scr_idx;
   logic              scr_hit;
   logic              wr_mask_en;
   logic              wr_mask_dis;
   logic              wr_src_set;
   logic              wr_src_clr;
   logic              wr_end_serv;
   logic              enc_take;

   assign req = '{sel: i_psel, enable: i_penable, write: i_pwrite,
                  addr: i_paddr, wdata: i_pwdata};
   assign access    = req.sel & req.enable;
   assign rd_encode = access & ~req.write & (req.addr == ENCODE_OFF);
   assign wr_cmd    = access & req.write;
   assign o_pready  = 1'b1;

   // Offset 0 would be channel 0, which has no source and no control word
   assign scr_idx     = req.addr[6:2];
   assign scr_hit     = (req.addr[11:7] == 5'h00) && (scr_idx != 5'h00);
   assign wr_mask_en  = wr_cmd && (req.addr == MASK_EN_OFF);
   assign wr_mask_dis = wr_cmd && (req.addr == MASK_DIS_OFF);
   assign wr_src_set  = wr_cmd && (req.addr == SRC_SET_OFF);
   assign wr_src_clr  = wr_cmd && (req.addr == SRC_CLR_OFF);
   assign wr_end_serv = wr_cmd && (req.addr == END_SERV_OFF);
   // Good encode read: IRQ still up and a winner above current level
   assign enc_take    = rd_encode && irq_r && valid_hit;

   // Source synchroniser and edge history
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= i_src & ~RESERVED_CH & ~32'h0000_0001;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // One cell per channel: control word, sense decode, edge pending
   for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      chan_sense_cell u_cell (
         .i_clk       (i_clk),
         .i_rst_n     (i_rst_n),
         .i_ctl_we    (wr_cmd && scr_hit && (scr_idx == 5'(g))),
         .i_ctl_wdata (req.wdata[7:0]),
         .i_level     (sync2_r[g]),
         .i_prev      (prev_r[g]),
         .i_set       (wr_src_set && req.wdata[g]),
         .i_clr       (wr_src_clr && req.wdata[g]),
         .i_ack       (enc_take && (win_ch == 5'(g))),
         .o_ctl       (ctl[g]),
         .o_status    (status[g])
      );
      assign lvl0_ch[g] = (ctl[g][LVL_LSB+:3] == 3'h0);
   end

   assign active = status & mask_r & ~RESERVED_CH & ~32'h0000_0001;

   // Winner: lowest level, then lowest channel
   always_comb begin
      win_ch  = 5'h00;
      win_lvl = 4'h8;
      win_any = 1'b0;
      for (int c = NUM_CH-1; c >= 1; c--) begin
         if (active[c] && ({1'b0, ctl[c][LVL_LSB+:3]} <= win_lvl)) begin
            win_ch  = c[4:0];
            win_lvl = {1'b0, ctl[c][LVL_LSB+:3]};
            win_any = 1'b1;
         end
      end
   end

   // Only strictly more urgent than current level may interrupt
   assign valid_hit = win_any && (win_lvl < cur_lvl_r);

   // Mask: enable and disable touch only written bits
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         mask_r <= MASK_RESET;
      else if (wr_mask_en)
         mask_r <= mask_r | req.wdata;
      else if (wr_mask_dis)
         mask_r <= mask_r & ~req.wdata;
   end

   // Level stack; depth 8 covers every level nested once
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         depth_r   <= 4'h0;
         cur_lvl_r <= 4'h8;
         for (int i = 0; i < NUM_LVL; i++)
            stack_r[i] <= '0;
      end else if (enc_take) begin
         stack_r[depth_r[2:0]] <= {4'h0, cur_lvl_r};
         depth_r   <= depth_r + 4'h1;
         cur_lvl_r <= win_lvl;
      end else if (wr_end_serv && depth_r != 4'h0) begin
         depth_r   <= depth_r - 4'h1;
         cur_lvl_r <= stack_r[depth_r[2:0] - 3'h1][3:0];
      end
   end

   // IRQ line: dropped by encode read, raised for a more urgent winner of level 1 to 7
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         irq_r <= 1'b0;
      else if (rd_encode)
         irq_r <= 1'b0;
      else
         irq_r <= valid_hit && win_lvl != 4'h0;
   end

   assign o_irq_request_n = ~irq_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_fast_irq_request <= 1'b0;
      else
         o_fast_irq_request <= |(active & lvl0_ch);
   end

   // Latched source number, kept until next encode read
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         src_num_r <= 5'h00;
      else if (rd_encode)
         src_num_r <= enc_take ? win_ch : 5'h00;
   end

   // Read mux; stale IRQ or no winner yields the zero vector
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (req.addr)
         ENCODE_OFF:
            if (irq_r && valid_hit)
               rdata_nxt = {25'h0, win_ch, 2'h0};
         RAW_STAT_OFF:   rdata_nxt = sync2_r;
         ACT_STAT_OFF:   rdata_nxt = status;
         PEND_STAT_OFF:  rdata_nxt = active;
         SRC_NUM_OFF:    rdata_nxt = {27'h0, src_num_r};
         MASK_STATE_OFF: rdata_nxt = mask_r;
         OUT_STAT_OFF:   rdata_nxt = {30'h0, irq_r, o_fast_irq_request};
         default:
            if (scr_hit)
               rdata_nxt = {24'h0, ctl[scr_idx]};
      endcase
   end

   assign o_prdata  = (access && !req.write) ? rdata_nxt : 32'h0000_0000;
   assign o_pslverr = 1'b0;
endmodule // vector_irq_ctrl

// Per-channel control word, sense decode and edge pending flag
module chan_sense_cell (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ctl_we,
   input  wire logic [7:0] i_ctl_wdata,
   input  wire logic       i_level,
   input  wire logic       i_prev,
   input  wire logic       i_set,
   input  wire logic       i_clr,
   input  wire logic       i_ack,
   output logic      [7:0] o_ctl,
   output logic            o_status
);
   import vector_irq_pkg::*;

   logic [1:0] mode;
   logic       is_edge;
   logic       edge_hit;
   logic       level_on;
   logic       pend_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_ctl <= SCR_RESET;
      else if (i_ctl_we)
         o_ctl <= i_ctl_wdata;
   end

   assign mode    = o_ctl[MODE_LSB+:2];
   assign is_edge = mode[1];

   always_comb begin
      edge_hit = 1'b0;
      level_on = 1'b0;
      case (sense_e'(mode))
         SENSE_LOW:  level_on = ~i_level;
         SENSE_HIGH: level_on = i_level;
         SENSE_FALL: edge_hit = i_prev & ~i_level;
         SENSE_RISE: edge_hit = ~i_prev & i_level;
         default:    level_on = 1'b0;
      endcase
   end

   // Hardware edge wins so an edge in the clear cycle is never lost
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         pend_r <= 1'b0;
      else if (!is_edge)
         pend_r <= 1'b0;
      else if (edge_hit)
         pend_r <= 1'b1;
      else if (i_set)
         pend_r <= 1'b1;
      else if (i_clr || i_ack)
         pend_r <= 1'b0;
   end

   assign o_status = is_edge ? pend_r : level_on;
endmodule // chan_sense_cell

// ==== vector_irq_pkg.sv ====
// Purpose: Shared constants and types for the vectored interrupt controller
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes:   Source control fields are per channel: level in [2:0], mode [7:6]
package vector_irq_pkg;
   localparam int          NUM_CH         = 32;
   localparam int          NUM_LVL        = 8;
   localparam logic [11:0] SCR_BASE       = 12'h000;
   localparam logic [11:0] RAW_STAT_OFF   = 12'h100;
   localparam logic [11:0] ACT_STAT_OFF   = 12'h104;
   localparam logic [11:0] PEND_STAT_OFF  = 12'h108;
   localparam logic [11:0] ENCODE_OFF     = 12'h10c;
   localparam logic [11:0] SRC_NUM_OFF    = 12'h110;
   localparam logic [11:0] MASK_STATE_OFF = 12'h114;
   localparam logic [11:0] OUT_STAT_OFF   = 12'h118;
   localparam logic [11:0] MASK_EN_OFF    = 12'h120;
   localparam logic [11:0] MASK_DIS_OFF   = 12'h124;
   localparam logic [11:0] SRC_SET_OFF    = 12'h128;
   localparam logic [11:0] SRC_CLR_OFF    = 12'h12c;
   localparam logic [11:0] END_SERV_OFF   = 12'h130;
   localparam logic [7:0]  SCR_RESET      = 8'h47;
   localparam int          LVL_LSB        = 0;
   localparam int          MODE_LSB       = 6;
   localparam logic [31:0] RESERVED_CH    = 32'h01a0_01b1;
   localparam logic [31:0] MASK_RESET     = 32'h0000_0000;

   typedef enum logic [1:0] {
      SENSE_LOW  = 2'h0,
      SENSE_HIGH = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } sense_e;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } apb_req_s;
endpackage

// ==== vector_irq_chk_assertions.sv ====
// Purpose: Port checks for the vectored interrupt controller
// Assumes: Zero-wait APB, read data only in access phase
// Notes:   Bound to every controller instance at the foot
`timescale 1ns/10ps
module vector_irq_chk
   import vector_irq_pkg::*;
(
   input wire logic                                i_clk,
   input wire logic                                i_rst_n,
   input wire logic                                i_psel,
   input wire logic                                i_penable,
   input wire logic                                i_pwrite,
   input wire logic [11:0]                         i_paddr,
   input wire logic [31:0]                         o_prdata,
   input wire logic                                o_pready,
   input wire logic                                o_pslverr,
   input wire logic                                o_irq_request_n,
   input wire logic                                o_fast_irq_request
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic acc = i_psel & i_penable & !i_pwrite;
   wire logic enc = acc & (i_paddr == ENCODE_OFF);
   logic [31:0] vec_r;
   // Fake reads latch zero as well, as the source number does
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) vec_r <= '0;
      else if (enc) vec_r <= o_prdata;
   end
   chk_ready_tied: assert property (o_pready) else $error("pready low");
   chk_no_slverr: assert property (!o_pslverr) else $error("slverr set");
   chk_idle_rdata: assert property (!(i_psel && i_penable) |-> o_prdata == 0)
      else $error("read data outside access");
   chk_vec_aligned: assert property (enc |-> o_prdata[1:0] == 2'h0)
      else $error("vector not word aligned");
   chk_vec_range: assert property (enc |-> o_prdata[31:7] == '0)
      else $error("vector beyond channel 31");
   chk_read_drops: assert property (enc && o_prdata != 0 |=> o_irq_request_n)
      else $error("irq kept after encode read");
   chk_fake_zero: assert property (enc && o_irq_request_n |-> o_prdata == 0)
      else $error("vector without irq");
   chk_srcnum_hold: assert property (acc && i_paddr == SRC_NUM_OFF |->
      o_prdata == {2'h0, vec_r[31:2]}) else $error("source number");
   cover property (enc && o_prdata != 0);
   cover property (enc && o_prdata == 0);
   cover property ($rose(o_fast_irq_request));
endmodule // vector_irq_chk

bind vector_irq_ctrl vector_irq_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_irq_request_n(o_irq_request_n),
   .o_fast_irq_request(o_fast_irq_request));

// ==== core_irq_model.sv ====
// Purpose: Core side model counting interrupt entries
// Assumes: The bench plays the handler and reads promptly
// Notes:   Fast entries counted apart from ordinary ones
`timescale 1ns/10ps
module core_irq_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_irq_request_n,
   input  wire logic       i_fast_irq_request,
   output logic      [7:0] o_irq_entries,
   output logic      [7:0] o_fast_entries
);
   logic irq_d_r;
   logic fast_d_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_d_r        <= 1'b1;
         fast_d_r       <= 1'b0;
         o_irq_entries  <= 8'h00;
         o_fast_entries <= 8'h00;
      end else begin
         irq_d_r  <= i_irq_request_n;
         fast_d_r <= i_fast_irq_request;
         // Entry on each falling irq request edge and each rising fast request edge
         if (irq_d_r && !i_irq_request_n) o_irq_entries <= o_irq_entries + 8'h01;
         if (!fast_d_r && i_fast_irq_request) o_fast_entries <= o_fast_entries + 8'h01;
      end
   end
endmodule // core_irq_model

// ==== vector_irq_ctrl_test.sv ====
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero-wait APB, three-cycle source path
// Notes:   Bench plays the interrupt handler
`timescale 1ns/10ps
module vector_irq_ctrl_test;
   import vector_irq_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   apb_req_s    req = '0;
   logic [31:0] src = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        irq_n;
   logic        fast;
   logic [7:0]  irq_cnt;
   logic [7:0]  fast_cnt;
   int          n_errors = 0;
   int          check_count = 0;
   always #5 clk = ~clk;
   vector_irq_ctrl DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(req.sel),
      .i_penable(req.enable), .i_pwrite(req.write), .i_paddr(req.addr),
      .i_pwdata(req.wdata), .i_src(src), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(), .o_irq_request_n(irq_n), .o_fast_irq_request(fast));
   core_irq_model core (.i_clk(clk), .i_rst_n(rst_n), .i_irq_request_n(irq_n),
      .i_fast_irq_request(fast), .o_irq_entries(irq_cnt),
      .o_fast_entries(fast_cnt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.enable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      req <= '0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic idle();
      repeat (4) @(posedge clk);
   endtask
   task automatic sset(input logic [31:0] v);
      @(posedge clk);
      src <= v;
      idle();
   endtask
   task automatic t_reset();
      rd(SCR_BASE + 12'h004, 32'h47);
      rd(MASK_STATE_OFF, 32'h0);
      rd(ENCODE_OFF, 32'h0);
   endtask
   task automatic t_prio();
      wr(SCR_BASE + 12'h018, {24'h0, SENSE_HIGH, 6'h03});
      wr(SCR_BASE + 12'h024, {24'h0, SENSE_HIGH, 6'h03});
      wr(MASK_EN_OFF, 32'h240);
      rd(MASK_STATE_OFF, 32'h240);
      sset(32'h240);
      chk(32'(irq_n), 32'h0);
      rd(ENCODE_OFF, 32'h18);
      idle();
      chk(32'(irq_n), 32'h1);
      rd(SRC_NUM_OFF, 32'h6);
   endtask
   task automatic t_nest();
      wr(SCR_BASE + 12'h008, {24'h0, SENSE_HIGH, 6'h01});
      wr(MASK_EN_OFF, 32'h4);
      sset(32'h244);
      chk(32'(irq_n), 32'h0);
      rd(ENCODE_OFF, 32'h8);
      sset(32'h240);
      wr(END_SERV_OFF, 32'h0);
      idle();
      chk(32'(irq_n), 32'h1);
      wr(END_SERV_OFF, 32'h0);
      idle();
      chk(32'(irq_n), 32'h0);
      rd(ENCODE_OFF, 32'h18);
      sset(32'h0);
      wr(END_SERV_OFF, 32'h0);
      wr(MASK_DIS_OFF, 32'h240);
      rd(MASK_STATE_OFF, 32'h4);
   endtask
   task automatic t_edge();
      wr(SCR_BASE + 12'h028, {24'h0, SENSE_RISE, 6'h04});
      wr(MASK_EN_OFF, 32'h400);
      wr(SRC_SET_OFF, 32'h400);
      idle();
      chk(32'(irq_n), 32'h0);
      wr(SRC_CLR_OFF, 32'h400);
      idle();
      chk(32'(irq_n), 32'h1);
      wr(SRC_SET_OFF, 32'h400);
      idle();
      rd(ENCODE_OFF, 32'h28);
      wr(END_SERV_OFF, 32'h0);
      idle();
      chk(32'(irq_n), 32'h1);
   endtask
   task automatic t_fast();
      wr(SCR_BASE + 12'h00c, {24'h0, SENSE_HIGH, 6'h00});
      wr(MASK_EN_OFF, 32'h8);
      sset(32'h8);
      chk({fast, irq_n}, 32'h3);
      rd(ENCODE_OFF, 32'h0);
      chk(32'(fast), 32'h1);
      sset(32'h0);
      chk(32'(fast), 32'h0);
      chk({fast_cnt, irq_cnt}, 32'h105);
   endtask
   task automatic t_sense();
      wr(SCR_BASE + 12'h02c, {24'h0, SENSE_FALL, 6'h05});
      wr(MASK_EN_OFF, 32'h800);
      sset(32'h800);
      chk(32'(irq_n), 32'h1);
      sset(32'h0);
      idle();
      chk(32'(irq_n), 32'h0);
      rd(ENCODE_OFF, 32'h2c);
      wr(END_SERV_OFF, 32'h0);
      wr(MASK_DIS_OFF, 32'h800);
      wr(SCR_BASE + 12'h02c, {24'h0, SENSE_LOW, 6'h05});
      rd(ACT_STAT_OFF, 32'h800);
      rd(PEND_STAT_OFF, 32'h0);
   endtask
   task automatic give_verdict();
      $display("errors=%0d checks=%0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_prio();
      t_nest();
      t_edge();
      t_fast();
      t_sense();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule // vector_irq_ctrl_test
